/* File: rtl/jtag_chain_consts.vh */
// constants for the jtag test access chain and its wishbone register file
`ifndef JTAG_CHAIN_CONSTS_VH
`define JTAG_CHAIN_CONSTS_VH

// ****************************************************************
// chain shape
// ****************************************************************
`define NUM_TILES 2
`define IR_W 4
`define IR_CAPTURE 4'h1
`define BSC_W 8

// ****************************************************************
// instruction codes, shared by both tap kinds
// ****************************************************************
`define INS_EXTEST 4'h0
`define INS_IDCODE 4'h1
`define INS_SAMPLE 4'h2
`define INS_USERCODE 4'h3
`define INS_DEBUG 4'h4
`define INS_OTP 4'h5
`define INS_BYPASS 4'hf

// ****************************************************************
// identification and user code fields (values are arbitrary)
// ****************************************************************
`define ID_VERSION 4'h1
`define ID_PART 16'h0abc
`define ID_MANUF 11'h2aa
`define UC_UNUSED 4'h0
`define UC_REVISION 18'h00001

// ****************************************************************
// security register bits
// ****************************************************************
`define SEC_JTAG_OFF 0
`define SEC_OTP_BLOCK 13
`define SEC_UID_HI 31
`define SEC_UID_LO 22
`define SEC_RESET 32'h00000000

// ****************************************************************
// wishbone byte addresses
// ****************************************************************
`define ADR_SEC0 8'h00
`define ADR_SEC1 8'h04
`define ADR_TX0 8'h08
`define ADR_TX1 8'h0c
`define ADR_RX0 8'h10
`define ADR_RX1 8'h14
`define ADR_STATUS 8'h18
`define ADR_OTP_RD 8'h1c
`define ADR_OTP_WR0 8'h20
`define ADR_OTP_WR1 8'h24

// ****************************************************************
// timing
// ****************************************************************
`define CLK_NS 40
`define TRST_MIN_NS 100
`define TRST_MIN_CYC ((`TRST_MIN_NS + `CLK_NS - 1) / `CLK_NS)

`endif

/* File: rtl/jtag_chain.v */
// jtag chain of boundary scan and chip taps per tile, with wishbone registers
//
// Added by the designer: register access over Wishbone and the address map.
`include "jtag_chain_consts.vh"

// Notes on behaviour
// - two taps per tile in chain after reset
// - boundary tap follows 1149.1, scans io pins
// - chip tap reaches tile debug registers and otp
// - test reset low keeps tap state, instructions and tdo reset; data and update registers hold
// - idcode: version, part, maker, lsb one
// - usercode: user id, unused, silicon revision
// - user id from tile 0 security top bits
// - security bit 0 disables tile jtag access
// - security bit 13 blocks jtag otp access
// - security top bits hold user id extension
module jtag_chain (
    // clock and reset
    input wire clk_sys_in,
    input wire rst_n_in,
    // jtag pins
    input wire tck_in,
    input wire tms_in,
    input wire tdi_in,
    input wire trst_n_in,
    output wire tdo_out,
    output reg tdo_oe_out,
    // boundary scanned pins
    input wire [`NUM_TILES*`BSC_W-1:0] pad_in_in,
    input wire [`NUM_TILES*`BSC_W-1:0] core_out_in,
    output wire [`NUM_TILES*`BSC_W-1:0] pad_out_out,
    // wishbone slave
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out
);

    // ****************************************************************
    // tap controller states, one-hot
    // ****************************************************************
    localparam [15:0] S_TLR = 16'h0001;
    localparam [15:0] S_RTI = 16'h0002;
    localparam [15:0] S_SDS = 16'h0004;
    localparam [15:0] S_CDR = 16'h0008;
    localparam [15:0] S_SDR = 16'h0010;
    localparam [15:0] S_E1D = 16'h0020;
    localparam [15:0] S_PDR = 16'h0040;
    localparam [15:0] S_E2D = 16'h0080;
    localparam [15:0] S_UDR = 16'h0100;
    localparam [15:0] S_SIS = 16'h0200;
    localparam [15:0] S_CIR = 16'h0400;
    localparam [15:0] S_SIR = 16'h0800;
    localparam [15:0] S_E1I = 16'h1000;
    localparam [15:0] S_PIR = 16'h2000;
    localparam [15:0] S_E2I = 16'h4000;
    localparam [15:0] S_UIR = 16'h8000;

    // ****************************************************************
    // functions
    // ****************************************************************
    // standard tap state walk
    function [15:0] tap_next;
        input [15:0] st;
        input tms;
        begin
            case (st)
                S_TLR: tap_next = tms ? S_TLR : S_RTI;
                S_RTI: tap_next = tms ? S_SDS : S_RTI;
                S_SDS: tap_next = tms ? S_SIS : S_CDR;
                S_CDR: tap_next = tms ? S_E1D : S_SDR;
                S_SDR: tap_next = tms ? S_E1D : S_SDR;
                S_E1D: tap_next = tms ? S_UDR : S_PDR;
                S_PDR: tap_next = tms ? S_E2D : S_PDR;
                S_E2D: tap_next = tms ? S_UDR : S_SDR;
                S_UDR: tap_next = tms ? S_SDS : S_RTI;
                S_SIS: tap_next = tms ? S_TLR : S_CIR;
                S_CIR: tap_next = tms ? S_E1I : S_SIR;
                S_SIR: tap_next = tms ? S_E1I : S_SIR;
                S_E1I: tap_next = tms ? S_UIR : S_PIR;
                S_PIR: tap_next = tms ? S_E2I : S_PIR;
                S_E2I: tap_next = tms ? S_UIR : S_SIR;
                S_UIR: tap_next = tms ? S_SDS : S_RTI;
                default: tap_next = S_TLR;
            endcase
        end
    endfunction

    // boundary tap knows extest, sample, idcode; the rest is bypass
    function [3:0] eff_bscan;
        input [3:0] ir;
        begin
            case (ir)
                `INS_EXTEST, `INS_SAMPLE, `INS_IDCODE: eff_bscan = ir;
                default: eff_bscan = `INS_BYPASS;
            endcase
        end
    endfunction

    // chip tap; security bits turn protected paths into bypass
    function [3:0] eff_chip;
        input [3:0] ir;
        input [31:0] sec;
        begin
            case (ir)
                `INS_IDCODE, `INS_USERCODE: eff_chip = ir;
                `INS_DEBUG: eff_chip = sec[`SEC_JTAG_OFF] ? `INS_BYPASS : ir;
                `INS_OTP: eff_chip = (sec[`SEC_JTAG_OFF] | sec[`SEC_OTP_BLOCK]) ?
                    `INS_BYPASS : ir;
                default: eff_chip = `INS_BYPASS;
            endcase
        end
    endfunction

    // length of the selected data register
    function [5:0] dr_len;
        input [3:0] code;
        begin
            case (code)
                `INS_IDCODE, `INS_USERCODE, `INS_DEBUG, `INS_OTP: dr_len = 6'd32;
                `INS_EXTEST, `INS_SAMPLE: dr_len = 6'd8;
                default: dr_len = 6'd1;
            endcase
        end
    endfunction

    // shift toward bit 0, new bit enters at the top of the active length
    function [31:0] dr_shift;
        input [31:0] d;
        input si;
        input [5:0] len;
        integer i;
        begin
            for (i = 0; i < 32; i = i + 1) begin
                if (i == len - 1)
                    dr_shift[i] = si;
                else if (i < len - 1 && i < 31)
                    dr_shift[i] = d[i + 1];
                else
                    dr_shift[i] = 1'b0;
            end
        end
    endfunction

    // byte-lane write merge
    function [31:0] wmask;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] sel;
        integer b;
        begin
            for (b = 0; b < 32; b = b + 1)
                wmask[b] = sel[b / 8] ? nw[b] : old[b];
        end
    endfunction

    // ****************************************************************
    // pin synchronisers and tck edge detection
    // ****************************************************************
    reg [3:0] pin_s1_r;
    reg [3:0] pin_s2_r;
    reg tck_d_r;
    reg [`NUM_TILES*`BSC_W-1:0] pad_s1_r;
    reg [`NUM_TILES*`BSC_W-1:0] pad_s2_r;
    wire tck_s = pin_s2_r[0];
    wire tms_s = pin_s2_r[1];
    wire tdi_s = pin_s2_r[2];
    wire tap_rst = ~pin_s2_r[3];
    wire tck_rise = tck_s & ~tck_d_r;
    wire tck_fall = ~tck_s & tck_d_r;

    // tck is sampled, so jtag pins go through two flops before use
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            tck_d_r <= 1'b0;
            pad_s1_r <= {`NUM_TILES*`BSC_W{1'b0}};
            pad_s2_r <= {`NUM_TILES*`BSC_W{1'b0}};
        end else begin
            pin_s1_r <= {trst_n_in, tdi_in, tms_in, tck_in};
            pin_s2_r <= pin_s1_r;
            tck_d_r <= tck_s;
            pad_s1_r <= pad_in_in;
            pad_s2_r <= pad_s1_r;
        end
    end

    // ****************************************************************
    // shared tap state machine
    // ****************************************************************
    // all taps see the same tck and tms, so one walker serves them all
    reg [15:0] st_r;
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= S_TLR;
            tdo_oe_out <= 1'b0;
        end else if (tap_rst) begin
            st_r <= S_TLR;
            tdo_oe_out <= 1'b0;
        end else begin
            if (tck_rise)
                st_r <= tap_next(st_r, tms_s);
            if (tck_fall)
                tdo_oe_out <= (st_r == S_SDR) | (st_r == S_SIR);
        end
    end

    // ****************************************************************
    // wishbone registers written by software
    // ****************************************************************
    reg [`NUM_TILES*32-1:0] sec_r;
    reg [`NUM_TILES*32-1:0] tx_r;
    reg [31:0] otp_rd_r;
    wire [`NUM_TILES*32-1:0] rx_w;
    wire [`NUM_TILES*32-1:0] otpw_w;
    wire [`NUM_TILES*2:0] chain_in;
    assign chain_in[0] = tdi_s;
    assign tdo_out = chain_in[`NUM_TILES*2]; // last chip tap output flop
    wire [31:0] idcode = {`ID_VERSION, `ID_PART, `ID_MANUF, 1'b1};
    // user id from tile 0 security, unused field forced to zero
    wire [31:0] usercode = {sec_r[`SEC_UID_HI:`SEC_UID_LO], `UC_UNUSED,
        `UC_REVISION};

    // ****************************************************************
    // per tile: boundary scan tap then chip tap
    // ****************************************************************
    genvar t;
    generate
        for (t = 0; t < `NUM_TILES; t = t + 1) begin : gen_tile
            reg [3:0] ir_b_r;
            reg [3:0] irs_b_r;
            reg [31:0] dr_b_r;
            reg so_b_r;
            reg [`BSC_W-1:0] upd_r;
            reg [`BSC_W-1:0] pad_r;
            reg [3:0] ir_c_r;
            reg [3:0] irs_c_r;
            reg [31:0] dr_c_r;
            reg so_c_r;
            reg [31:0] rx_r;
            reg [31:0] otpw_r;
            wire [31:0] sec = sec_r[32*t +: 32];
            wire [3:0] eb = eff_bscan(ir_b_r);
            wire [3:0] ec = eff_chip(ir_c_r, sec);
            wire si_b = chain_in[2*t];
            wire si_c = chain_in[2*t+1];
            assign chain_in[2*t+1] = so_b_r;
            assign chain_in[2*t+2] = so_c_r;
            assign rx_w[32*t +: 32] = rx_r;
            assign otpw_w[32*t +: 32] = otpw_r;
            assign pad_out_out[`BSC_W*t +: `BSC_W] = pad_r;

            // capture and shift on tck rise, update and tdo on tck fall
            always @(posedge clk_sys_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    ir_b_r <= `INS_IDCODE;
                    irs_b_r <= 4'h0;
                    dr_b_r <= 32'h00000000;
                    so_b_r <= 1'b0;
                    upd_r <= {`BSC_W{1'b0}};
                    ir_c_r <= `INS_IDCODE;
                    irs_c_r <= 4'h0;
                    dr_c_r <= 32'h00000000;
                    so_c_r <= 1'b0;
                    rx_r <= 32'h00000000;
                    otpw_r <= 32'h00000000;
                end else if (tap_rst || st_r == S_TLR) begin
                    ir_b_r <= `INS_IDCODE;
                    ir_c_r <= `INS_IDCODE;
                    so_b_r <= 1'b0;
                    so_c_r <= 1'b0;
                end else begin
                    if (tck_rise) begin
                        if (st_r == S_CIR) begin
                            irs_b_r <= `IR_CAPTURE;
                            irs_c_r <= `IR_CAPTURE;
                        end
                        if (st_r == S_SIR) begin
                            irs_b_r <= {si_b, irs_b_r[3:1]};
                            irs_c_r <= {si_c, irs_c_r[3:1]};
                        end
                        if (st_r == S_CDR) begin
                            case (eb)
                                `INS_IDCODE: dr_b_r <= idcode;
                                `INS_EXTEST, `INS_SAMPLE:
                                    dr_b_r <= {24'h000000, pad_s2_r[`BSC_W*t +: `BSC_W]};
                                default: dr_b_r <= 32'h00000000;
                            endcase
                            case (ec)
                                `INS_IDCODE: dr_c_r <= idcode;
                                `INS_USERCODE: dr_c_r <= usercode;
                                `INS_DEBUG: dr_c_r <= tx_r[32*t +: 32];
                                `INS_OTP: dr_c_r <= otp_rd_r;
                                default: dr_c_r <= 32'h00000000;
                            endcase
                        end
                        if (st_r == S_SDR) begin
                            dr_b_r <= dr_shift(dr_b_r, si_b, dr_len(eb));
                            dr_c_r <= dr_shift(dr_c_r, si_c, dr_len(ec));
                        end
                    end
                    if (tck_fall) begin
                        so_b_r <= (st_r == S_SIR) ? irs_b_r[0] : dr_b_r[0];
                        so_c_r <= (st_r == S_SIR) ? irs_c_r[0] : dr_c_r[0];
                        if (st_r == S_UIR) begin
                            ir_b_r <= irs_b_r;
                            ir_c_r <= irs_c_r;
                        end
                        if (st_r == S_UDR) begin
                            if (eb == `INS_EXTEST || eb == `INS_SAMPLE)
                                upd_r <= dr_b_r[`BSC_W-1:0];
                            if (ec == `INS_DEBUG)
                                rx_r <= dr_c_r;
                            if (ec == `INS_OTP)
                                otpw_r <= dr_c_r;
                        end
                    end
                end
            end

            // pads follow the core unless extest drives them from the cells
            always @(posedge clk_sys_in or negedge rst_n_in) begin
                if (!rst_n_in)
                    pad_r <= {`BSC_W{1'b0}};
                else
                    pad_r <= (eb == `INS_EXTEST) ? upd_r : core_out_in[`BSC_W*t +: `BSC_W];
            end
        end
    endgenerate

    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    wire [7:0] adr = {wb_adr_in[7:2], 2'b00};
    wire [31:0] status = {24'h000000, 2'b00, sec_r[32+`SEC_OTP_BLOCK], sec_r[`SEC_OTP_BLOCK],
        sec_r[32+`SEC_JTAG_OFF], sec_r[`SEC_JTAG_OFF], tap_rst, st_r == S_TLR};
    reg [31:0] rd_nxt;

    // read mux; unmapped addresses read zero
    always @* begin
        case (adr)
            `ADR_SEC0: rd_nxt = sec_r[31:0];
            `ADR_SEC1: rd_nxt = sec_r[63:32];
            `ADR_TX0: rd_nxt = tx_r[31:0];
            `ADR_TX1: rd_nxt = tx_r[63:32];
            `ADR_RX0: rd_nxt = rx_w[31:0];
            `ADR_RX1: rd_nxt = rx_w[63:32];
            `ADR_STATUS: rd_nxt = status;
            `ADR_OTP_RD: rd_nxt = otp_rd_r;
            `ADR_OTP_WR0: rd_nxt = otpw_w[31:0];
            `ADR_OTP_WR1: rd_nxt = otpw_w[63:32];
            default: rd_nxt = 32'h00000000;
        endcase
    end

    // ack one cycle after the strobe, dropped the next cycle
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h00000000;
            sec_r <= {`NUM_TILES{`SEC_RESET}}; // unprogrammed: user id zero
            tx_r <= {`NUM_TILES*32{1'b0}};
            otp_rd_r <= 32'h00000000;
        end else begin
            wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
            if (wb_cyc_in && wb_stb_in && !wb_ack_out) begin
                wb_dat_out <= wb_we_in ? 32'h00000000 : rd_nxt;
                if (wb_we_in) begin
                    case (adr)
                        `ADR_SEC0: sec_r[31:0] <= wmask(sec_r[31:0], wb_dat_in, wb_sel_in);
                        `ADR_SEC1: sec_r[63:32] <= wmask(sec_r[63:32], wb_dat_in, wb_sel_in);
                        `ADR_TX0: tx_r[31:0] <= wmask(tx_r[31:0], wb_dat_in, wb_sel_in);
                        `ADR_TX1: tx_r[63:32] <= wmask(tx_r[63:32], wb_dat_in, wb_sel_in);
                        `ADR_OTP_RD: otp_rd_r <= wmask(otp_rd_r, wb_dat_in, wb_sel_in);
                        default: otp_rd_r <= otp_rd_r;
                    endcase
                end
            end
        end
    end

endmodule

/* File: bench/jtag_chain_props.sv */
// assertion checker watching the jtag chain ports
`include "jtag_chain_consts.vh"
module jtag_chain_props (
    // clock and reset
    input wire clk_sys_in,
    input wire rst_n_in,
    // jtag pins
    input wire tck_in,
    input wire trst_n_in,
    input wire tdo_out,
    input wire tdo_oe_out,
    // scanned pins
    input wire [`NUM_TILES*`BSC_W-1:0] core_out_in,
    input wire [`NUM_TILES*`BSC_W-1:0] pad_out_out,
    // wishbone
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [31:0] wb_dat_out,
    input wire wb_ack_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    // ****************
    // wishbone answer
    // ****************
    a_ack_next: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("ack did not follow a request");
    a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held longer than one cycle");
    a_write_zero: assert property (wb_ack_out && wb_we_in |-> wb_dat_out == 32'h0)
        else $error("read data not zero on a write");
    // space above the last register must answer zero
    a_unmapped_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in[7:2] > 6'h09
        |-> wb_dat_out == 32'h0) else $error("unmapped read not zero");
    // ****************
    // test port
    // ****************
    // sync latency is two edges, five leaves margin for the output flop
    a_trst_quiet: assert property (!trst_n_in [*5] |-> !tdo_out && !tdo_oe_out)
        else $error("tdo active while test reset held");
    a_pad_follow: assert property (
        !trst_n_in [*5] |-> pad_out_out == $past(core_out_in))
        else $error("pads not driven by core while test reset held");
    // tdo moves only after a tck fall, never deep in the high phase
    a_tdo_hold: assert property (tck_in [*3] |-> $stable(tdo_out))
        else $error("tdo changed while tck high");
    a_oe_hold: assert property (tck_in [*3] |-> $stable(tdo_oe_out))
        else $error("tdo enable changed while tck high");
    c_read: cover property (wb_ack_out && !wb_we_in);
    c_shift: cover property (tdo_oe_out);
    c_trst: cover property (!trst_n_in ##1 trst_n_in);
endmodule

/* File: bench/jtag_host_model.sv */
// behavioural jtag controller driving the test port from outside
module jtag_host_model (
    // clock
    input wire clk_sys_in,
    // jtag pins
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    output logic trst_n_out,
    input wire tdo_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    logic frame_tdi;
    logic idle_tdi;
    // frame bits while scanning, a moving filler between frames
    assign tdi_out = busy ? frame_tdi : idle_tdi;
    // test reset low from power-up, tck parked low between frames
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b0;
        frame_tdi = 1'b0;
        idle_tdi = 1'b0;
        trst_n_out = 1'b0;
        busy = 1'b0;
    end
    // tdi is not meaningful between frames, so it keeps moving
    always @(posedge clk_sys_in) begin
        idle_tdi <= ~idle_tdi;
    end
    // hold test reset for n clocks, then give the sync time to settle
    task automatic hold_reset(input int n);
        trst_n_out <= 1'b0;
        repeat (n) @(posedge clk_sys_in);
        trst_n_out <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
    endtask
    // one 320 ns tck period; tdo taken late in the high phase
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        tms_out <= tms;
        frame_tdi <= tdi;
        repeat (4) @(posedge clk_sys_in);
        tck_out <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        tdo = tdo_in;
        tck_out <= 1'b0;
    endtask
    // full ir or dr scan from idle back to idle, lsb first
    task automatic scan(input logic ir, input logic [127:0] din, input int n,
                        output logic [127:0] dout);
        logic t;
        busy = 1'b1;
        dout = '0;
        tick(1'b0, 1'b0, t); // leaves test-logic-reset if still there
        tick(1'b1, 1'b0, t);
        if (ir) tick(1'b1, 1'b0, t);
        tick(1'b0, 1'b0, t);
        tick(1'b0, 1'b0, t);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], t);
            dout[i] = t;
        end
        tick(1'b1, 1'b0, t);
        tick(1'b0, 1'b0, t);
        busy = 1'b0;
    endtask
endmodule

/* File: bench/jtag_chain_tb.sv */
// self-checking bench for the jtag chain with a model controller
`include "jtag_chain_consts.vh"
module jtag_chain_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] idc = {`ID_VERSION, `ID_PART, `ID_MANUF, 1'b1};
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [15:0] pad_in = 16'h3c96, core_out = 16'ha5c3;
    wire tck, tms, tdi, trst_n, tdo, tdo_oe, ack;
    wire [15:0] pad_out;
    wire [31:0] rdat;
    int mismatches = 0, checks_done = 0;
    always #20 clk_sys_in = ~clk_sys_in;
    jtag_chain dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .tck_in(tck), .tms_in(tms),
        .tdi_in(tdi), .trst_n_in(trst_n), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
        .pad_in_in(pad_in), .core_out_in(core_out), .pad_out_out(pad_out),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
        .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack));
    jtag_host_model u_host (.clk_sys_in(clk_sys_in), .tck_out(tck), .tms_out(tms),
        .tdi_out(tdi), .trst_n_out(trst_n), .tdo_in(tdo));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [127:0] exp, input logic [127:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // classic single cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int k;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hf;
        adr <= a;
        wdat <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_sys_in);
            if (ack === 1'b1) break;
        end
        if (k == 20) begin
            mismatches++;
            $display("MISMATCH wishbone ack expected 1 seen none");
            finish_test();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        cmp(what, exp, q);
    endtask
    // load all four instruction registers, then scan the selected data path
    task automatic jt(input string what, input logic [15:0] ir, input logic [127:0] din,
                      input int n, input logic [127:0] exp);
        logic [127:0] q;
        u_host.scan(1'b1, {112'h0, ir}, 16, q);
        cmp("ir capture", 128'h1111, q);
        u_host.scan(1'b0, din, n, q);
        cmp(what, exp, q);
    endtask
    task automatic idcodes();
        logic [127:0] q;
        u_host.scan(1'b0, '0, 128, q);
        cmp("idcodes", {4{idc}}, q);
    endtask
    initial begin
        logic [9:0] uid;
        logic [31:0] uc;
        repeat (5) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        u_host.hold_reset(`TRST_MIN_CYC + 1);
        idcodes();
        $display("test idcode after reset done");
        // unprogrammed id first, then a pattern; tile 1 bits must not leak in
        for (int s = 0; s < 2; s++) begin
            uid = s ? 10'h2a5 : 10'h000;
            uc = {uid, 4'h0, `UC_REVISION};
            wr(`ADR_SEC0, {uid, 22'h0});
            wr(`ADR_SEC1, {10'h3ff, 22'h0});
            jt("usercode", 16'hf3f3, '0, 66, {62'h0, 1'b0, uc, 1'b0, uc});
        end
        $display("test usercode done");
        wr(`ADR_SEC0, 32'h0);
        wr(`ADR_TX0, 32'h5a5a1234);
        jt("debug capture", 16'hf4ff, {94'h0, 32'hc3c30f0f, 2'b00}, 35,
           {94'h0, 32'h5a5a1234, 2'b00});
        rd(`ADR_RX0, 32'hc3c30f0f, "rx0 after debug update");
        wr(`ADR_OTP_RD, 32'h0bad1dea);
        jt("otp capture", 16'hfff5, {96'h0, 32'h600dcafe}, 35, {96'h0, 32'h0bad1dea});
        rd(`ADR_OTP_WR1, 32'h600dcafe, "otp write word");
        $display("test debug access done");
        // sample on tile 0 cells, extest on tile 1 cells in one scan
        jt("boundary capture", 16'h2f0f, {110'h0, 8'h00, 1'b0, 8'h5e, 1'b0}, 18,
           {110'h0, pad_in[7:0], 1'b0, pad_in[15:8], 1'b0});
        cmp("pad drive", {8'h5e, core_out[7:0]}, pad_out);
        $display("test boundary scan done");
        wr(`ADR_SEC0, 32'h00000001);
        wr(`ADR_SEC1, 32'h00002000);
        jt("blocked as bypass", 16'hf4f5, '1, 8, 128'hf0);
        rd(`ADR_STATUS, 32'h24, "status secured");
        wr(8'h3c, 32'hffffffff);
        rd(8'h3c, 32'h0, "unmapped read");
        $display("test security done");
        fork
            u_host.hold_reset(12);
            begin
                repeat (6) @(posedge clk_sys_in);
                rd(`ADR_STATUS, 32'h27, "status in test reset");
                core_out <= 16'h1234;
            end
        join
        cmp("pads after test reset", 16'h1234, pad_out);
        rd(`ADR_SEC0, 32'h1, "sec0 kept over test reset");
        idcodes();
        $display("test mid-run test reset done");
        finish_test();
    end
endmodule
bind jtag_chain jtag_chain_props u_props (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .tck_in(tck_in), .trst_n_in(trst_n_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
    .core_out_in(core_out_in), .pad_out_out(pad_out_out), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out));
